// File: shared/gip_pkg.sv
// Package: bus codes, field layouts and carrier types for the instrument port
package gip_pkg;
  localparam int GIP_DATA_W = 8;
  localparam int GIP_ADDR_W = 5;
  // Field positions inside a command byte
  localparam int GIP_GRP_HI = 6;
  localparam int GIP_GRP_LO = 5;
  localparam int GIP_ADR_HI = 4;
  localparam int GIP_ADR_LO = 0;
  // Groups by bits 6..5
  localparam logic [1:0] GIP_GRP_CMD = 2'h0;
  localparam logic [1:0] GIP_GRP_LSN = 2'h1;
  localparam logic [1:0] GIP_GRP_TLK = 2'h2;
  localparam logic [1:0] GIP_GRP_SEC = 2'h3;
  localparam logic [4:0] GIP_ADR_ALL = 5'h1f;
  // Addressed commands
  localparam logic [6:0] GIP_CMD_GTL = 7'h01;
  localparam logic [6:0] GIP_CMD_SDC = 7'h04;
  localparam logic [6:0] GIP_CMD_PPC = 7'h05;
  localparam logic [6:0] GIP_CMD_GET = 7'h08;
  localparam logic [6:0] GIP_CMD_TCT = 7'h09;
  // Universal commands
  localparam logic [6:0] GIP_CMD_LLO = 7'h11;
  localparam logic [6:0] GIP_CMD_DCL = 7'h14;
  localparam logic [6:0] GIP_CMD_PPU = 7'h15;
  localparam logic [6:0] GIP_CMD_SPE = 7'h18;
  localparam logic [6:0] GIP_CMD_SPD = 7'h19;
  localparam logic [7:0] GIP_BYTE_RST = 8'h00;

  typedef struct packed {
    logic [GIP_DATA_W-1:0] data;
    logic last;
  } gip_word_s;

  typedef struct packed {
    logic atn;
    logic eoi;
    logic ifc;
    logic ren;
    logic dav;
    logic nrfd;
    logic ndac;
    logic [GIP_DATA_W-1:0] dio;
  } gip_bus_s;
endpackage

// File: src/gip_buf2.sv
// Two-entry valid/ready buffer for data words
`timescale 1ns/1ps
module gip_buf2 #(
  parameter int WIDTH = 9
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_ff [2];
  logic wr_ptr_ff;
  logic rd_ptr_ff;
  logic [1:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: src/gip_port.sv
// Instrument-side bus port: handshake, address and command decode
`timescale 1ns/1ps
module gip_port (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [gip_pkg::GIP_ADDR_W-1:0] addr_sw_i,
  input wire logic atn_n_i,
  input wire logic eoi_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  input wire logic dav_n_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  input wire logic [gip_pkg::GIP_DATA_W-1:0] dio_n_i,
  output logic [gip_pkg::GIP_DATA_W-1:0] dio_n_o,
  output logic dio_oe_o,
  output logic dav_n_o,
  output logic dav_oe_o,
  output logic eoi_n_o,
  output logic eoi_oe_o,
  output logic nrfd_n_o,
  output logic nrfd_oe_o,
  output logic ndac_n_o,
  output logic ndac_oe_o,
  output logic srq_n_o,
  output logic srq_oe_o,
  input wire logic srq_req_i,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output gip_pkg::gip_word_s rx_word_o,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire gip_pkg::gip_word_s tx_word_i,
  output logic listener_o,
  output logic talker_o,
  output logic remote_o,
  output logic lockout_o,
  output logic spoll_o,
  output logic poll_o,
  output logic dev_clear_o,
  output logic trigger_o,
  output logic go_local_o
);
  import gip_pkg::*;

  typedef enum logic [3:0] {
    GIP_L_IDLE = 4'b0001,
    GIP_L_READY = 4'b0010,
    GIP_L_TAKE = 4'b0100,
    GIP_L_WAIT = 4'b1000
  } gip_lst_e;

  typedef enum logic [3:0] {
    GIP_T_IDLE = 4'b0001,
    GIP_T_SETUP = 4'b0010,
    GIP_T_VALID = 4'b0100,
    GIP_T_DONE = 4'b1000
  } gip_tlk_e;

  gip_bus_s raw;
  gip_bus_s meta_ff;
  gip_bus_s bus_ff;
  gip_lst_e lst_ff;
  gip_tlk_e tlk_ff;
  logic [4:0] my_addr_ff;
  logic listener_ff;
  logic talker_ff;
  logic remote_ff;
  logic lockout_ff;
  logic spoll_ff;
  logic [GIP_DATA_W-1:0] rx_byte_ff;
  logic rx_last_ff;
  logic rx_atn_ff;
  logic cmd_stb_ff;
  logic dat_stb_ff;
  logic dev_clear_ff;
  logic trigger_ff;
  logic go_local_ff;
  logic [GIP_DATA_W-1:0] dio_ff;
  logic eoi_ff;
  logic dav_ff;
  logic buf_in_ready;
  logic tx_pop;
  logic [1:0] grp;
  logic [4:0] adr;
  logic [6:0] code;

  function automatic logic is_cmd(input logic [6:0] c, input logic [6:0] ref_c);
    is_cmd = (c == ref_c);
  endfunction

  // Bus levels inverted to active-high truth
  assign raw = '{atn: ~atn_n_i, eoi: ~eoi_n_i, ifc: ~ifc_n_i, ren: ~ren_n_i, dav: ~dav_n_i,
                 nrfd: ~nrfd_n_i, ndac: ~ndac_n_i, dio: ~dio_n_i};

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      bus_ff <= '0;
    end else begin
      meta_ff <= raw;
      bus_ff <= meta_ff;
    end
  end

  // Switch re-read whenever both handshakes are idle and the port is neither listener nor talker
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      my_addr_ff <= 5'h1f;
    end else if (lst_ff == GIP_L_IDLE && tlk_ff == GIP_T_IDLE && !listener_ff && !talker_ff) begin
      my_addr_ff <= addr_sw_i;
    end
  end

  // Fields of the last byte taken, used by the decoder
  assign grp = rx_byte_ff[GIP_GRP_HI:GIP_GRP_LO];
  assign adr = rx_byte_ff[GIP_ADR_HI:GIP_ADR_LO];
  assign code = rx_byte_ff[6:0];

  // Listener handshake; attention bytes always accepted
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      lst_ff <= GIP_L_IDLE;
      rx_byte_ff <= GIP_BYTE_RST;
      rx_last_ff <= 1'b0;
      rx_atn_ff <= 1'b0;
    end else begin
      case (lst_ff)
        GIP_L_IDLE: begin
          if ((bus_ff.atn || (listener_ff && buf_in_ready)) && !bus_ff.dav) begin
            lst_ff <= GIP_L_READY;
          end
        end
        GIP_L_READY: begin
          if (!bus_ff.atn && !(listener_ff && buf_in_ready)) begin
            lst_ff <= GIP_L_IDLE;
          end else if (bus_ff.dav) begin
            rx_byte_ff <= bus_ff.dio;
            rx_atn_ff <= bus_ff.atn;
            rx_last_ff <= bus_ff.eoi && !bus_ff.atn;
            lst_ff <= GIP_L_TAKE;
          end
        end
        GIP_L_TAKE: begin
          lst_ff <= GIP_L_WAIT;
        end
        GIP_L_WAIT: begin
          if (!bus_ff.dav) begin
            lst_ff <= GIP_L_IDLE;
          end
        end
        default: begin
          lst_ff <= GIP_L_IDLE;
        end
      endcase
    end
  end

  // Strobes for the decoder and the data path
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cmd_stb_ff <= 1'b0;
      dat_stb_ff <= 1'b0;
    end else begin
      cmd_stb_ff <= (lst_ff == GIP_L_TAKE) && rx_atn_ff;
      dat_stb_ff <= (lst_ff == GIP_L_TAKE) && !rx_atn_ff && listener_ff;
    end
  end

  // Not-ready held unless idle-ready, under attention or as a listener with buffer space
  assign nrfd_oe_o = (lst_ff != GIP_L_READY) && (bus_ff.atn || listener_ff);
  assign nrfd_n_o = 1'b0;
  // Not-accepted held until the byte is taken
  assign ndac_oe_o = (lst_ff == GIP_L_IDLE || lst_ff == GIP_L_READY || lst_ff == GIP_L_TAKE)
                     && (bus_ff.atn || listener_ff);
  assign ndac_n_o = 1'b0;

  // Interface command decode
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || bus_ff.ifc) begin
      listener_ff <= 1'b0;
      talker_ff <= 1'b0;
      spoll_ff <= 1'b0;
    end else if (cmd_stb_ff) begin
      case (grp)
        GIP_GRP_LSN: begin
          if (adr == GIP_ADR_ALL) begin
            listener_ff <= 1'b0;
          end else if (adr == my_addr_ff) begin
            listener_ff <= 1'b1;
          end
        end
        GIP_GRP_TLK: begin
          if (adr == GIP_ADR_ALL) begin
            talker_ff <= 1'b0;
          end else begin
            talker_ff <= (adr == my_addr_ff);
          end
        end
        GIP_GRP_CMD: begin
          if (is_cmd(code, GIP_CMD_SPE)) begin
            spoll_ff <= 1'b1;
          end else if (is_cmd(code, GIP_CMD_SPD)) begin
            spoll_ff <= 1'b0;
          end
        end
        default: begin
          spoll_ff <= spoll_ff;
        end
      endcase
    end
  end

  // Remote and lockout follow remote-enable
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      remote_ff <= 1'b0;
      lockout_ff <= 1'b0;
    end else if (!bus_ff.ren) begin
      remote_ff <= 1'b0;
      lockout_ff <= 1'b0;
    end else if (cmd_stb_ff) begin
      if (rx_byte_ff[6:5] == GIP_GRP_LSN && rx_byte_ff[4:0] == my_addr_ff) begin
        remote_ff <= 1'b1;
      end else if (listener_ff && is_cmd(rx_byte_ff[6:0], GIP_CMD_GTL) && !lockout_ff) begin
        remote_ff <= 1'b0;
      end
      if (is_cmd(rx_byte_ff[6:0], GIP_CMD_LLO)) begin
        lockout_ff <= 1'b1;
      end
    end
  end

  // One-cycle command pulses; take control and poll configure are not supported
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dev_clear_ff <= 1'b0;
      trigger_ff <= 1'b0;
      go_local_ff <= 1'b0;
    end else begin
      dev_clear_ff <= cmd_stb_ff && (is_cmd(rx_byte_ff[6:0], GIP_CMD_DCL)
                      || (listener_ff && is_cmd(rx_byte_ff[6:0], GIP_CMD_SDC)));
      trigger_ff <= cmd_stb_ff && listener_ff && is_cmd(rx_byte_ff[6:0], GIP_CMD_GET);
      go_local_ff <= cmd_stb_ff && listener_ff && is_cmd(rx_byte_ff[6:0], GIP_CMD_GTL);
    end
  end

  assign listener_o = listener_ff;
  assign talker_o = talker_ff;
  assign remote_o = remote_ff;
  assign lockout_o = lockout_ff;
  assign spoll_o = spoll_ff;
  assign poll_o = bus_ff.eoi && bus_ff.atn;
  assign dev_clear_o = dev_clear_ff;
  assign trigger_o = trigger_ff;
  assign go_local_o = go_local_ff;

  // Incoming data words to the device parser; not-ready also covers a full buffer
  gip_buf2 #(
    .WIDTH(GIP_DATA_W + 1)
  ) u_rx_buf (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(dat_stb_ff),
    .in_ready_o(buf_in_ready),
    .in_data_i({rx_byte_ff, rx_last_ff}),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_word_o)
  );

  // Talker handshake
  assign tx_ready_o = talker_ff && !bus_ff.atn && (tlk_ff == GIP_T_IDLE);
  assign tx_pop = tx_valid_i && tx_ready_o;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || bus_ff.ifc) begin
      tlk_ff <= GIP_T_IDLE;
      dio_ff <= GIP_BYTE_RST;
      eoi_ff <= 1'b0;
      dav_ff <= 1'b0;
    end else begin
      case (tlk_ff)
        GIP_T_IDLE: begin
          if (tx_pop) begin
            dio_ff <= tx_word_i.data;
            eoi_ff <= tx_word_i.last;
            tlk_ff <= GIP_T_SETUP;
          end
        end
        GIP_T_SETUP: begin
          if (bus_ff.atn || !talker_ff) begin
            tlk_ff <= GIP_T_DONE;
          end else if (!bus_ff.nrfd && !bus_ff.dav) begin
            dav_ff <= 1'b1;
            tlk_ff <= GIP_T_VALID;
          end
        end
        GIP_T_VALID: begin
          if (!bus_ff.ndac) begin
            dav_ff <= 1'b0;
            tlk_ff <= GIP_T_DONE;
          end
        end
        GIP_T_DONE: begin
          dav_ff <= 1'b0;
          eoi_ff <= 1'b0;
          tlk_ff <= GIP_T_IDLE;
        end
        default: begin
          tlk_ff <= GIP_T_IDLE;
        end
      endcase
    end
  end

  // Data lines held through setup and valid so the byte is stable under data-valid
  assign dio_oe_o = talker_ff && (tlk_ff == GIP_T_SETUP || tlk_ff == GIP_T_VALID);
  assign dio_n_o = ~dio_ff;
  assign dav_oe_o = dav_ff;
  assign dav_n_o = 1'b0;
  assign eoi_oe_o = eoi_ff && dio_oe_o;
  assign eoi_n_o = 1'b0;
  assign srq_oe_o = srq_req_i && !spoll_ff;
  assign srq_n_o = 1'b0;
endmodule

// File: verification/gip_ctl_model.sv
// Bus controller model with pulled-up wired-OR lines
`timescale 1ns/1ps
module gip_ctl_model (
  input wire logic clk_sys_i,
  input wire logic dio_oe_i,
  input wire logic [7:0] dio_i,
  input wire logic dav_oe_i,
  input wire logic eoi_oe_i,
  input wire logic nrfd_oe_i,
  input wire logic ndac_oe_i,
  output logic atn_n_o,
  output logic eoi_n_o,
  output logic ifc_n_o,
  output logic ren_n_o,
  output logic dav_n_o,
  output logic nrfd_n_o,
  output logic ndac_n_o,
  output logic [7:0] dio_n_o
);
  logic m_atn = 1'b0;
  logic m_eoi = 1'b0;
  logic m_ifc = 1'b0;
  logic m_ren = 1'b0;
  logic m_dav = 1'b0;
  logic m_nrfd = 1'b0;
  logic m_ndac = 1'b1;
  logic [7:0] m_dio = 8'h00;
  // Released lines float high through the pull-ups
  assign atn_n_o = !m_atn;
  assign ifc_n_o = !m_ifc;
  assign ren_n_o = !m_ren;
  assign eoi_n_o = !(m_eoi | eoi_oe_i);
  assign dav_n_o = !(m_dav | dav_oe_i);
  assign nrfd_n_o = !(m_nrfd | nrfd_oe_i);
  assign ndac_n_o = !(m_ndac | ndac_oe_i);
  assign dio_n_o = ~(m_dio | (dio_oe_i ? ~dio_i : 8'h00));
  task automatic put(input logic atn, input logic eoi, input logic [7:0] b, output logic ok);
    int n;
    m_atn <= atn;
    m_ndac <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    for (n = 0; n < 200 && nrfd_n_o !== 1'b1; n++) @(posedge clk_sys_i);
    m_dio <= b;
    m_eoi <= eoi;
    @(posedge clk_sys_i);
    m_dav <= 1'b1;
    for (n = 0; n < 200 && ndac_n_o !== 1'b1; n++) @(posedge clk_sys_i);
    ok = (ndac_n_o === 1'b1);
    m_dav <= 1'b0;
    m_eoi <= 1'b0;
    m_dio <= 8'h00;
    m_ndac <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask
  // Slow listener: dly stretches the accept phase
  task automatic get(input int dly, output logic [7:0] b, output logic last, output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 200 && dav_n_o !== 1'b0; n++) @(posedge clk_sys_i);
    if (dav_n_o !== 1'b0) return;
    repeat (dly) @(posedge clk_sys_i);
    b = ~dio_n_o;
    last = !eoi_n_o;
    m_nrfd <= 1'b1;
    m_ndac <= 1'b0;
    for (n = 0; n < 200 && dav_n_o !== 1'b1; n++) @(posedge clk_sys_i);
    m_ndac <= 1'b1;
    m_nrfd <= 1'b0;
    ok = (dav_n_o === 1'b1);
  endtask
endmodule

// File: verification/gip_instrument_port_bench.sv
// Self-checking bench for the instrument port
`timescale 1ns/1ps
module gip_instrument_port_bench;
  import gip_pkg::*;
  localparam logic [4:0] MY_ADR = 5'h0c;
  logic clk_sys_i, rst_n_i, srq_req_i, rx_ready_i, tx_valid_i;
  logic rx_valid_o, tx_ready_o, listener_o, talker_o, remote_o;
  logic lockout_o, spoll_o, poll_o, dev_clear_o, trigger_o, go_local_o;
  logic dio_oe_o, dav_oe_o, eoi_oe_o, nrfd_oe_o, ndac_oe_o, srq_oe_o;
  logic atn_n_i, eoi_n_i, ifc_n_i, ren_n_i, dav_n_i, nrfd_n_i, ndac_n_i;
  logic [7:0] dio_n_i, dio_n_o, b;
  logic last, ok;
  gip_word_s tx_word_i, rx_word_o;
  int mismatches, comparisons, trig_n, clr_n, loc_n;
  gip_port uut (
    .clk_sys_i, .rst_n_i, .addr_sw_i(MY_ADR), .atn_n_i, .eoi_n_i, .ifc_n_i, .ren_n_i,
    .dav_n_i, .nrfd_n_i, .ndac_n_i, .dio_n_i, .dio_n_o, .dio_oe_o, .dav_n_o(), .dav_oe_o,
    .eoi_n_o(), .eoi_oe_o, .nrfd_n_o(), .nrfd_oe_o, .ndac_n_o(), .ndac_oe_o, .srq_n_o(),
    .srq_oe_o, .srq_req_i, .rx_valid_o, .rx_ready_i, .rx_word_o, .tx_valid_i, .tx_ready_o,
    .tx_word_i, .listener_o, .talker_o, .remote_o, .lockout_o, .spoll_o, .poll_o,
    .dev_clear_o, .trigger_o, .go_local_o
  );
  gip_ctl_model ctl (
    .clk_sys_i, .dio_oe_i(dio_oe_o), .dio_i(dio_n_o), .dav_oe_i(dav_oe_o), .eoi_oe_i(eoi_oe_o),
    .nrfd_oe_i(nrfd_oe_o), .ndac_oe_i(ndac_oe_o), .atn_n_o(atn_n_i), .eoi_n_o(eoi_n_i),
    .ifc_n_o(ifc_n_i), .ren_n_o(ren_n_i), .dav_n_o(dav_n_i), .nrfd_n_o(nrfd_n_i),
    .ndac_n_o(ndac_n_i), .dio_n_o(dio_n_i)
  );
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (trigger_o === 1'b1) trig_n++;
    if (dev_clear_o === 1'b1) clr_n++;
    if (go_local_o === 1'b1) loc_n++;
  end
  task automatic conclude;
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic snd(input logic atn, input logic eoi, input logic [7:0] v);
    ctl.put(atn, eoi, v, ok);
    chk("handshake", 1'b1, ok);
    if (ok !== 1'b1) conclude();
  endtask
  task automatic push(input gip_word_s w);
    int n;
    tx_word_i <= w;
    tx_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    for (n = 0; n < 50 && tx_ready_o !== 1'b1; n++) @(posedge clk_sys_i);
    chk("tx taken", 1'b1, tx_ready_o);
    if (tx_ready_o !== 1'b1) conclude();
    tx_valid_i <= 1'b0;
  endtask
  task automatic t_listen;
    ctl.m_ren <= 1'b1;
    snd(1'b1, 1'b0, {1'b0, GIP_GRP_LSN, MY_ADR});
    chk("listener", 1'b1, listener_o);
    chk("remote", 1'b1, remote_o);
    // Receiver stalls: both words must wait in the buffer, in order
    rx_ready_i <= 1'b0;
    snd(1'b0, 1'b0, 8'h41);
    snd(1'b0, 1'b1, 8'h42);
    chk("rx valid", 1'b1, rx_valid_o);
    chk("rx word", {8'h41, 1'b0}, rx_word_o);
    rx_ready_i <= 1'b1;
    tick(1);
    rx_ready_i <= 1'b0;
    tick(1);
    chk("rx word 2", {8'h42, 1'b1}, rx_word_o);
    rx_ready_i <= 1'b1;
    tick(3);
    chk("rx drained", 1'b0, rx_valid_o);
    snd(1'b1, 1'b0, {1'b0, GIP_CMD_GET});
    chk("trigger", 10'd1, trig_n);
    snd(1'b1, 1'b0, {1'b0, GIP_CMD_GTL});
    chk("go local", 10'd1, loc_n);
    chk("local on go", 1'b0, remote_o);
    ctl.m_eoi <= 1'b1;
    tick(4);
    chk("poll", 1'b1, poll_o);
    chk("no end", 1'b0, rx_valid_o);
    ctl.m_eoi <= 1'b0;
  endtask
  task automatic t_cmds;
    snd(1'b1, 1'b0, 8'h3f);
    chk("unlisten", 1'b0, listener_o);
    snd(1'b1, 1'b0, {1'b0, GIP_CMD_GET});
    chk("trigger unaddressed", 10'd1, trig_n);
    snd(1'b1, 1'b0, {1'b0, GIP_CMD_DCL});
    chk("clear", 10'd1, clr_n);
    snd(1'b1, 1'b0, {1'b0, GIP_GRP_SEC, MY_ADR});
    chk("secondary", 1'b0, listener_o | talker_o);
    srq_req_i <= 1'b1;
    snd(1'b1, 1'b0, {1'b0, GIP_CMD_SPE});
    chk("serial poll", 1'b1, spoll_o);
    chk("srq held", 1'b0, srq_oe_o);
    snd(1'b1, 1'b0, {1'b0, GIP_CMD_SPD});
    chk("srq", 1'b1, srq_oe_o);
    snd(1'b1, 1'b0, {1'b0, GIP_CMD_LLO});
    chk("lockout", 1'b1, lockout_o);
    srq_req_i <= 1'b0;
  endtask
  task automatic t_talk;
    snd(1'b1, 1'b0, {1'b0, GIP_GRP_TLK, MY_ADR});
    chk("talker", 1'b1, talker_o);
    ctl.m_atn <= 1'b0;
    tick(4);
    push({8'h52, 1'b1});
    ctl.get(3, b, last, ok);
    chk("talk byte", {8'h52, 1'b1, 1'b1}, {b, last, ok});
    if (ok !== 1'b1) conclude();
    push({8'h0d, 1'b0});
    ctl.get(0, b, last, ok);
    chk("talk byte 2", {8'h0d, 1'b0, 1'b1}, {b, last, ok});
    if (ok !== 1'b1) conclude();
    snd(1'b1, 1'b0, 8'h5f);
    chk("untalk", 1'b0, talker_o);
    snd(1'b1, 1'b0, {1'b0, GIP_GRP_TLK, MY_ADR});
    snd(1'b1, 1'b0, {1'b0, GIP_GRP_TLK, 5'h03});
    chk("other talker", 1'b0, talker_o);
    snd(1'b1, 1'b0, {1'b0, GIP_GRP_LSN, MY_ADR});
    ctl.m_ifc <= 1'b1;
    tick(5);
    chk("ifc", 1'b0, listener_o);
    ctl.m_ifc <= 1'b0;
    ctl.m_ren <= 1'b0;
    tick(4);
    chk("local", 1'b0, remote_o);
  endtask
  initial begin
    rst_n_i = 1'b0;
    srq_req_i = 1'b0;
    rx_ready_i = 1'b1;
    tx_valid_i = 1'b0;
    tx_word_i = '0;
    tick(5);
    rst_n_i <= 1'b1;
    tick(3);
    t_listen();
    t_cmds();
    t_talk();
    conclude();
  end
endmodule

// File: verification/gip_port_props.sv
// Concurrent checks on the instrument port pins and status
`timescale 1ns/1ps
module gip_port_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic atn_n_i,
  input wire logic eoi_n_i,
  input wire logic ifc_n_i,
  input wire logic dav_n_i,
  input wire logic nrfd_n_i,
  input wire logic ndac_n_i,
  input wire logic [gip_pkg::GIP_DATA_W-1:0] dio_n_o,
  input wire logic dio_oe_o,
  input wire logic dav_oe_o,
  input wire logic eoi_oe_o,
  input wire logic nrfd_oe_o,
  input wire logic ndac_oe_o,
  input wire logic srq_oe_o,
  input wire logic srq_req_i,
  input wire logic listener_o,
  input wire logic talker_o,
  input wire logic spoll_o,
  input wire logic poll_o
);
  import gip_pkg::*;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_ifc_held;
    !ifc_n_i [*4];
  endsequence
  sequence s_byte_taken;
    $fell(ndac_oe_o) && (listener_o || !$past(atn_n_i, 2));
  endsequence
  property p_ifc_clear;
    s_ifc_held |-> !listener_o && !talker_o;
  endproperty
  a_ifc_clear: assert property (p_ifc_clear) else $error("addressing kept under clear");
  // Gate on reset history so synchroniser reset values are not judged
  property p_poll;
    $past(rst_n_i, 2) |-> poll_o == (!$past(eoi_n_i, 2) && !$past(atn_n_i, 2));
  endproperty
  a_poll: assert property (p_poll) else $error("poll indication wrong");
  property p_srq;
    srq_oe_o == (srq_req_i && !spoll_o);
  endproperty
  a_srq: assert property (p_srq) else $error("service request wrong");
  property p_dav_data;
    dav_oe_o |-> dio_oe_o && $stable(dio_n_o);
  endproperty
  a_dav_data: assert property (p_dav_data) else $error("data moved under valid");
  property p_wait_rfd;
    $rose(dav_oe_o) |-> $past(nrfd_n_i, 3);
  endproperty
  a_wait_rfd: assert property (p_wait_rfd) else $error("valid before ready");
  property p_wait_dac;
    $fell(dav_oe_o) |-> $past(ndac_n_i, 3);
  endproperty
  a_wait_dac: assert property (p_wait_dac) else $error("valid dropped before accept");
  property p_hold_dac;
    s_byte_taken |-> !$past(dav_n_i, 2);
  endproperty
  a_hold_dac: assert property (p_hold_dac) else $error("accept without valid byte");
  property p_not_ready;
    s_byte_taken |-> nrfd_oe_o;
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("ready while taking byte");
  property p_eoi_last;
    eoi_oe_o |-> dio_oe_o;
  endproperty
  a_eoi_last: assert property (p_eoi_last) else $error("end flag without byte");
endmodule
bind gip_port gip_port_props u_props (
  .clk_sys_i, .rst_n_i, .atn_n_i, .eoi_n_i, .ifc_n_i, .dav_n_i, .nrfd_n_i, .ndac_n_i,
  .dio_n_o, .dio_oe_o, .dav_oe_o, .eoi_oe_o, .nrfd_oe_o, .ndac_oe_o, .srq_oe_o,
  .srq_req_i, .listener_o, .talker_o, .spoll_o, .poll_o
);
